// ==== cmr_defines.svh ====
// Register offsets, field positions, reset values and limits of the charger mask and converter slice
`ifndef CMR_DEFINES_SVH
`define CMR_DEFINES_SVH

`define CMR_OFS_MASK_A 8'h23
`define CMR_OFS_MASK_B 8'h24
`define CMR_OFS_FAULT_MASK 8'h25
`define CMR_OFS_CONV_CTRL 8'h26
`define CMR_OFS_CHAN_OFF 8'h27
`define CMR_OFS_IIN_HI 8'h28
`define CMR_OFS_IIN_LO 8'h29
`define CMR_OFS_IBAT_HI 8'h2A
`define CMR_OFS_IBAT_LO 8'h2B
`define CMR_OFS_VIN_HI 8'h2C
`define CMR_OFS_VIN_LO 8'h2D

`define CMR_MASK_A_RW 8'h7F
`define CMR_MASK_B_RW 8'h09
`define CMR_FAULT_MASK_RW 8'hF9
`define CMR_CONV_CTRL_RW 8'hFC
`define CMR_CONV_CTRL_RST 8'h30
`define CMR_MASK_RST 8'h00

`define CMR_BIT_ENABLE 7
`define CMR_BIT_ONESHOT 6
`define CMR_BIT_AVG 3
`define CMR_BIT_SEED 2

`define CMR_IIN_MAX 15'sh07D0
`define CMR_IIN_MIN 15'sh7830
`define CMR_IBAT_MAX 14'sh03E8
`define CMR_IBAT_MIN 14'sh38AD
`define CMR_IBAT_ABORT 14'h2000
`define CMR_VIN_MAX 13'h1388

`define CMR_IRQ_PULSE_NS 1000
`define CMR_CLK_NS 4
`define CMR_IRQ_PULSE_CYC ((`CMR_IRQ_PULSE_NS + `CMR_CLK_NS - 1) / `CMR_CLK_NS)

`endif

// ==== cmr_host.sv ====
// Host model driving the register bus of the charger slice
`timescale 1ns/1ps
`default_nettype none
module cmr_host
	import cmr_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Register bus
	output var cmr_bus_s bus,
	input wire logic [7:0] rdData
);
	initial bus = '0;
	// Released fields are scrambled so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk);
		bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
		@(negedge sys_clk);
		bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
		d = rdData;
	endtask
endmodule
`default_nettype wire

// ==== cmr_pkg.sv ====
// Types shared by the charger mask and converter slice
package cmr_pkg;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cmr_bus_s;

	typedef struct packed
	{
		logic valid;
		logic dirFlip;
		logic [15:0] iin;
		logic [15:0] ibat;
		logic [15:0] vin;
	} cmr_sample_s;

	typedef enum logic [1:0]
	{
		CMR_IDLE,
		CMR_CONVERT,
		CMR_DONE
	} cmr_conv_e;

endpackage

// ==== cmr_regs.sv ====
// Charger interrupt masks, converter control and current and voltage result registers
//
// Function
// R1: Bit 6 of mask A blocks the interrupt on one-shot conversion completion.
// R2: Bit 5 of mask A blocks the interrupt on entering die thermal regulation.
// R3: Bit 4 blocks interrupts on entering and leaving minimum system regulation.
// R4: Bit 3 blocks current-limit entry, bit 2 voltage-limit entry interrupts.
// R5: Bit 1 blocks charge timer expiry, bit 0 bus watchdog expiry interrupts.
// R6: Mask fields reset to zero at power-up and register reset; reserved read zero.
// R7: Mask B bit 3 charge state change, bit 0 input source change; others reserved.
// R8: Fault mask bits 7, 6, 5 block input, battery and system fault interrupts.
// R9: Fault mask bits 4, 3, 0 block boost, die shutdown, thermistor zone; 2:1 reserved.
// R10: Converter enable bit 7, cleared by register reset and by watchdog expiry.
// R11: Results reset to zero, then hold the latest value, even when disabled.
// R12: Control bit 6 selects continuous conversion at zero, one-shot at one.
// R13: Bits 5:4 set resolution 12 to 9 bits, reset code 3.
// R14: Averaging bit 3 reports a running average instead of single values.
// R15: Seed bit 2 starts the average from the held value or a fresh one.
// R16: Channel-off register excludes each channel with a one in its bit.
// R17: Input current is two's complement in bits 15:1, 2 mA a step.
// R18: Input current result clamped to minus and plus 4000 mA.
// R19: Battery current in bits 15:2, 4 mA steps, clamped -7500 to 4000 mA.
// R20: Battery current result forced to zero when charge enable is written zero.
// R21: Direction change during battery current conversion reports field code 2000h.
// R22: One-shot completion sets the conversion-complete flag; its mask gates only the interrupt.
// R23: Input voltage in bits 14:2, unsigned, clamped high at 1388h.
// R24: Interrupt output is an active-low pulse, only for unmasked events.
`include "cmr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cmr_regs
	import cmr_pkg::*;
#(
	parameter int PULSE_CYC = `CMR_IRQ_PULSE_CYC,
	parameter int CONV_CYC = 64
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	// Register access from the serial bus engine
	input wire cmr_bus_s bus,
	output logic [7:0] rdData,
	// Register-reset command and watchdog expiry, one-cycle pulses
	input wire logic regResetCmd,
	input wire logic watchdogExpired,
	// Charge enable write strobe and the value written
	input wire logic chargeAllowWr,
	input wire logic chargeAllow,
	// Charger events, one-cycle pulses: [6] reserved slot, [5] thermal reg entry,
	// [4] min system enter or exit, [3] current limit entry, [2] voltage limit entry,
	// [1] charge timer expiry, [0] watchdog expiry
	input wire logic [6:0] chargerEvent,
	// [3] charge state change, [0] input source change
	input wire logic [3:0] statusEvent,
	// [7] input fault, [6] battery, [5] system, [4] boost, [3] die shutdown, [0] thermistor zone
	input wire logic [7:0] faultEvent,
	// Measurement front end
	input wire cmr_sample_s sample,
	// Converter control to the front end
	output logic convEnable,
	output logic convStart,
	output logic [1:0] resolutionSel,
	output logic [7:0] chanOff,
	output logic convDoneFlag,
	// Interrupt
	output logic irq_n
);

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic [7:0] maskA_reg, maskB_reg, faultMask_reg, ctrl_reg, chanOff_reg;
	logic [15:0] iin_reg, ibat_reg, vin_reg;
	logic [15:0] iin_next, ibat_next, vin_next;
	logic [7:0] rdData_next;
	logic doneFlag_reg;
	logic [15:0] pulseCnt_reg;
	logic [15:0] convCnt_reg;
	cmr_conv_e state_reg;

	function automatic logic [15:0] avgOf(input logic [15:0] held, input logic [15:0] fresh);
		logic [16:0] s;
		s = {held[15], held} + {fresh[15], fresh};
		avgOf = s[16:1];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire logic wrEn = clkEn && bus.wr;
	wire logic wrMaskA = wrEn && bus.addr == `CMR_OFS_MASK_A;
	wire logic wrMaskB = wrEn && bus.addr == `CMR_OFS_MASK_B;
	wire logic wrFault = wrEn && bus.addr == `CMR_OFS_FAULT_MASK;
	wire logic wrCtrl = wrEn && bus.addr == `CMR_OFS_CONV_CTRL;
	wire logic wrChan = wrEn && bus.addr == `CMR_OFS_CHAN_OFF;
	wire logic oneShot = ctrl_reg[`CMR_BIT_ONESHOT]; // [R12]
	wire logic avgOn = ctrl_reg[`CMR_BIT_AVG]; // [R14]
	wire logic seedFresh = ctrl_reg[`CMR_BIT_SEED]; // [R15]
	wire logic sampleTake = sample.valid && ctrl_reg[`CMR_BIT_ENABLE];
	wire logic oneShotDone = state_reg == CMR_DONE;
	logic firstAvg_reg;

	// Clamps per result field
	// Current comparisons stay signed; the clamped code keeps the raw bit pattern
	wire logic signed [14:0] iinRaw = sample.iin[15:1];
	wire logic [14:0] iinClamp = (iinRaw > $signed(`CMR_IIN_MAX)) ? `CMR_IIN_MAX :
		(iinRaw < $signed(`CMR_IIN_MIN)) ? `CMR_IIN_MIN : iinRaw; // [R17] [R18]
	wire logic signed [13:0] ibatRaw = sample.ibat[15:2];
	wire logic [13:0] ibatClamp = (ibatRaw > $signed(`CMR_IBAT_MAX)) ? `CMR_IBAT_MAX :
		(ibatRaw < $signed(`CMR_IBAT_MIN)) ? `CMR_IBAT_MIN : ibatRaw; // [R19]
	wire logic [12:0] vinClamp = (sample.vin[14:2] > `CMR_VIN_MAX) ? `CMR_VIN_MAX : sample.vin[14:2]; // [R23]
	wire logic [15:0] iinFresh = {iinClamp, 1'b0};
	wire logic [15:0] ibatFresh = sample.dirFlip ? {`CMR_IBAT_ABORT, 2'b00} : {ibatClamp, 2'b00}; // [R21]
	wire logic [15:0] vinFresh = {1'b0, vinClamp, 2'b00};
	// Fresh seed on the first sample after averaging turns on, only when the seed bit is set
	wire logic useFresh = !avgOn || (firstAvg_reg && seedFresh); // [R14] [R15]

	// Running averages; the reserved low bits are dropped after the halving
	wire logic [15:0] iinAvg = avgOf(iin_reg, iinFresh); // [R14]
	wire logic [15:0] ibatAvg = avgOf(ibat_reg, ibatFresh);
	wire logic [15:0] vinAvg = avgOf(vin_reg, vinFresh);

	// Disabled channels keep their held value; an aborted battery sample is never averaged
	always_comb
	begin
		iin_next = iin_reg;
		ibat_next = ibat_reg;
		vin_next = vin_reg;
		if (sampleTake && !chanOff_reg[7]) // [R16]
		begin
			iin_next = useFresh ? iinFresh : {iinAvg[15:1], 1'b0};
		end
		if (sampleTake && !chanOff_reg[6])
		begin
			ibat_next = (useFresh || sample.dirFlip) ? ibatFresh : {ibatAvg[15:2], 2'b00};
		end
		if (sampleTake && !chanOff_reg[5])
		begin
			vin_next = useFresh ? vinFresh : {1'b0, vinAvg[14:2], 2'b00};
		end

		// A charge-disable write beats a sample landing in the same cycle
		if (chargeAllowWr && !chargeAllow)
		begin
			ibat_next = 16'h0000; // [R20]
		end
	end

	// Read mux, reserved bits zero through the stored masks
	// Result bytes are not snapshotted, so a host may see a torn pair
	assign rdData_next =
		(bus.addr == `CMR_OFS_MASK_A) ? maskA_reg :
		(bus.addr == `CMR_OFS_MASK_B) ? maskB_reg :
		(bus.addr == `CMR_OFS_FAULT_MASK) ? faultMask_reg :
		(bus.addr == `CMR_OFS_CONV_CTRL) ? ctrl_reg :
		(bus.addr == `CMR_OFS_CHAN_OFF) ? chanOff_reg :
		(bus.addr == `CMR_OFS_IIN_HI) ? iin_reg[15:8] :
		(bus.addr == `CMR_OFS_IIN_LO) ? iin_reg[7:0] :
		(bus.addr == `CMR_OFS_IBAT_HI) ? ibat_reg[15:8] :
		(bus.addr == `CMR_OFS_IBAT_LO) ? ibat_reg[7:0] :
		(bus.addr == `CMR_OFS_VIN_HI) ? vin_reg[15:8] :
		(bus.addr == `CMR_OFS_VIN_LO) ? vin_reg[7:0] : 8'h00;

	// Unmasked event detection
	wire logic [6:0] chgHit = chargerEvent & ~maskA_reg[6:0] & 7'h3F; // [R2] [R3] [R4] [R5]
	wire logic doneHit = oneShotDone && !maskA_reg[6]; // [R1] [R22]
	wire logic [3:0] statHit = statusEvent & ~maskB_reg[3:0] & 4'h9; // [R7]
	wire logic [7:0] faultHit = faultEvent & ~faultMask_reg & 8'hF9; // [R8] [R9]
	wire logic anyHit = doneHit || (|chgHit) || (|statHit) || (|faultHit); // [R24]

	////////////////////////////////////////////////////////////////////////////
	// Mask and control registers

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || (clkEn && regResetCmd))
		begin
			maskA_reg <= `CMR_MASK_RST; // [R6]
			maskB_reg <= `CMR_MASK_RST;
			faultMask_reg <= `CMR_MASK_RST;
			ctrl_reg <= `CMR_CONV_CTRL_RST; // [R13]
			chanOff_reg <= `CMR_MASK_RST;
		end
		else if (clkEn)
		begin
			if (wrMaskA)
			begin
				maskA_reg <= bus.wdata & `CMR_MASK_A_RW;
			end
			if (wrMaskB)
			begin
				maskB_reg <= bus.wdata & `CMR_MASK_B_RW; // [R7]
			end
			if (wrFault)
			begin
				faultMask_reg <= bus.wdata & `CMR_FAULT_MASK_RW; // [R9]
			end
			if (wrChan)
			begin
				chanOff_reg <= bus.wdata; // [R16]
			end
			if (wrCtrl)
			begin
				ctrl_reg <= bus.wdata & `CMR_CONV_CTRL_RW;
			end

			// Last, so expiry beats a control write in the same cycle
			if (watchdogExpired)
			begin
				ctrl_reg[`CMR_BIT_ENABLE] <= 1'b0; // [R10]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Results: power-up reset clears them, never the register-reset command

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			iin_reg <= 16'h0000; // [R11]
			ibat_reg <= 16'h0000;
			vin_reg <= 16'h0000;
			firstAvg_reg <= 1'b1;
		end
		else if (clkEn)
		begin
			iin_reg <= iin_next;
			ibat_reg <= ibat_next;
			vin_reg <= vin_next;

			// Turning averaging off re-arms the fresh seed
			if (!avgOn)
			begin
				firstAvg_reg <= 1'b1;
			end
			else if (sampleTake)
			begin
				firstAvg_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One-shot sequencer; continuous mode just keeps the front end enabled

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_reg <= CMR_IDLE;
			convCnt_reg <= 16'h0000;
			doneFlag_reg <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (state_reg)
				CMR_IDLE:
					if (ctrl_reg[`CMR_BIT_ENABLE] && oneShot)
					begin
						state_reg <= CMR_CONVERT;
						convCnt_reg <= 16'h0000;
					end
				// Dropping enable mid-pass abandons it with no done event
				CMR_CONVERT:
					if (!ctrl_reg[`CMR_BIT_ENABLE])
					begin
						state_reg <= CMR_IDLE;
					end
					else if (convCnt_reg == 16'(CONV_CYC - 1))
					begin
						state_reg <= CMR_DONE;
					end
					else
					begin
						convCnt_reg <= convCnt_reg + 16'h0001;
					end
				CMR_DONE:
					state_reg <= CMR_IDLE;
			endcase

			// Writing enable high clears the flag; a same-cycle done still sets it
			if (wrCtrl && bus.wdata[`CMR_BIT_ENABLE])
			begin
				doneFlag_reg <= 1'b0;
			end
			if (oneShotDone)
			begin
				doneFlag_reg <= 1'b1; // [R22]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs and interrupt pulse

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pulseCnt_reg <= 16'h0000;
			irq_n <= 1'b1;
			rdData <= 8'h00;
			convEnable <= 1'b0;
			convStart <= 1'b0;
			resolutionSel <= 2'h3;
			chanOff <= 8'h00;
			convDoneFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			// New event during a pulse restarts the width rather than being lost
			if (anyHit)
			begin
				pulseCnt_reg <= 16'(PULSE_CYC);
			end
			else if (pulseCnt_reg != 16'h0000)
			begin
				pulseCnt_reg <= pulseCnt_reg - 16'h0001;
			end
			irq_n <= !(anyHit || pulseCnt_reg > 16'h0001); // [R24]

			// Read data holds between strobes
			if (bus.rd)
			begin
				rdData <= rdData_next;
			end

			// Control copies lag the register by one cycle
			convEnable <= ctrl_reg[`CMR_BIT_ENABLE] && (!oneShot || state_reg == CMR_CONVERT); // [R10] [R12]
			convStart <= ctrl_reg[`CMR_BIT_ENABLE] && oneShot && state_reg == CMR_IDLE;
			resolutionSel <= ctrl_reg[5:4]; // [R13]
			chanOff <= chanOff_reg;
			convDoneFlag <= doneFlag_reg;
		end
	end

endmodule

`default_nettype wire

// ==== cmr_regs_checker.sv ====
// Concurrent checks on the ports of the charger mask and converter slice
`timescale 1ns/1ps
`default_nettype none
module cmr_regs_checker
	import cmr_pkg::*;
#(
	parameter int PULSE_CYC = 4
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Host side
	input wire cmr_bus_s bus,
	input wire logic [7:0] rdData,
	input wire logic regResetCmd,
	input wire logic watchdogExpired,
	input wire logic chargeAllowWr,
	input wire logic chargeAllow,
	// Events and samples
	input wire logic [6:0] chargerEvent,
	input wire logic [3:0] statusEvent,
	input wire logic [7:0] faultEvent,
	input wire cmr_sample_s sample,
	// Watched outputs
	input wire logic convEnable,
	input wire logic [1:0] resolutionSel,
	input wire logic convDoneFlag,
	input wire logic irq_n
);
	int lowCnt;
	wire logic anyEvent = |{chargerEvent, statusEvent, faultEvent};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Length of the current low stretch of the interrupt line
	always_ff @(posedge sys_clk) lowCnt <= (sys_rst || irq_n) ? 0 : lowCnt + 1;
	AST_IRQ_QUIET: assert property (irq_n && !convEnable && !anyEvent |=> irq_n)
		else $error("interrupt without an event");
	AST_IRQ_WIDTH: assert property ($rose(irq_n) |-> lowCnt >= PULSE_CYC)
		else $error("interrupt pulse too short");
	AST_MASKB_RSV: assert property (bus.rd && bus.addr == 8'h24 |=> (rdData & 8'hF6) == 8'h00)
		else $error("reserved bits set in mask B");
	AST_FAULT_RSV: assert property (bus.rd && bus.addr == 8'h25 |=> rdData[2:1] == 2'h0)
		else $error("reserved bits set in fault mask");
	AST_WDOG_EN: assert property (watchdogExpired |-> ##[1:2] !convEnable)
		else $error("enable survives watchdog");
	AST_REG_RST: assert property (regResetCmd |-> ##[1:2] (!convEnable && resolutionSel == 2'h3))
		else $error("control not reset");
	AST_IBAT_ZERO: assert property (chargeAllowWr && !chargeAllow && !sample.valid ##1 bus.rd && bus.addr == 8'h2A
		&& !sample.valid |=> rdData == 8'h00)
		else $error("battery result not cleared");
	AST_DONE_EN: assert property ($rose(convDoneFlag) |-> $past(convEnable, 2))
		else $error("done flag without enable");
endmodule
bind cmr_regs cmr_regs_checker #(.PULSE_CYC(PULSE_CYC)) chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
	.rdData(rdData), .regResetCmd(regResetCmd), .watchdogExpired(watchdogExpired), .chargeAllowWr(chargeAllowWr),
	.chargeAllow(chargeAllow), .chargerEvent(chargerEvent), .statusEvent(statusEvent), .faultEvent(faultEvent),
	.sample(sample), .convEnable(convEnable), .resolutionSel(resolutionSel), .convDoneFlag(convDoneFlag),
	.irq_n(irq_n));
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the charger mask and converter slice
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import cmr_pkg::*;
;
	logic sys_clk = 0, sys_rst = 1, clkEn = 1, regResetCmd = 0, watchdogExpired = 0;
	logic chargeAllowWr = 0, chargeAllow = 1, irq_n, convDoneFlag, convEnable, convStart;
	logic [1:0] resolutionSel;
	logic [7:0] chanOff;
	logic [18:0] ev = '0;
	logic [7:0] rdData;
	cmr_sample_s sample = '0;
	cmr_bus_s bus;
	int n_errors = 0, n_tests = 0;
	always #2 sys_clk = ~sys_clk;
	cmr_regs #(.PULSE_CYC(4), .CONV_CYC(8)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .bus(bus),
		.rdData(rdData), .regResetCmd(regResetCmd), .watchdogExpired(watchdogExpired), .chargeAllowWr(chargeAllowWr),
		.chargeAllow(chargeAllow), .chargerEvent(ev[18:12]), .statusEvent(ev[11:8]), .faultEvent(ev[7:0]),
		.sample(sample), .convEnable(convEnable), .convStart(convStart), .resolutionSel(resolutionSel),
		.chanOff(chanOff), .convDoneFlag(convDoneFlag),
		.irq_n(irq_n));
	cmr_host host_u (.sys_clk(sys_clk), .bus(bus), .rdData(rdData));
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_u.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	task automatic resChk(input logic [7:0] a, input logic [15:0] exp);
		logic [7:0] h;
		logic [7:0] l;
		host_u.rd(a, h);
		host_u.rd(8'(a + 8'h01), l);
		chk({h, l}, exp);
	endtask
	task automatic smp(input logic [15:0] i, input logic [15:0] b, input logic [15:0] v, input logic f);
		@(negedge sys_clk);
		sample = '{valid: 1'b1, dirFlip: f, iin: i, ibat: b, vin: v};
		@(negedge sys_clk);
		sample = '{valid: 1'b0, dirFlip: 1'b0, iin: ~i, ibat: ~b, vin: ~v};
	endtask
	task automatic fire(input int k, input logic exp);
		logic seen;
		seen = 1'b0;
		@(negedge sys_clk);
		ev = 19'h00001 << k;
		@(negedge sys_clk);
		ev = '0;
		repeat (12)
		begin
			@(negedge sys_clk);
			seen = seen | (irq_n === 1'b0);
		end
		chk({15'h0000, seen}, {15'h0000, exp});
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic tReset();
		for (int j = 8'h23; j < 8'h2E; j++)
			rdChk(8'(j), j == 8'h26 ? 8'h30 : 8'h00);
		rdChk(8'h40, 8'h00);
		chk({14'h0000, resolutionSel}, 16'h0003);
		chk({8'h00, chanOff}, 16'h0000);
		chk({15'h0000, convEnable}, 16'h0000);
	endtask
	task automatic tAccess();
		logic [7:0] rwm [0:4];
		rwm = '{8'h7F, 8'h09, 8'hF9, 8'hFC, 8'hFF};
		clkEn = 1'b0;
		host_u.wr(8'h23, 8'h55);
		clkEn = 1'b1;
		rdChk(8'h23, 8'h00);
		for (int j = 0; j < 5; j++)
			host_u.wr(8'(8'h23 + j), 8'hFF);
		host_u.wr(8'h28, 8'hFF);
		for (int j = 0; j < 5; j++)
			rdChk(8'(8'h23 + j), rwm[j]);
		rdChk(8'h28, 8'h00);
		@(negedge sys_clk);
		regResetCmd = 1'b1;
		@(negedge sys_clk);
		regResetCmd = 1'b0;
		for (int j = 0; j < 5; j++)
			rdChk(8'(8'h23 + j), j == 3 ? 8'h30 : 8'h00);
	endtask
	task automatic tEvents();
		logic [18:0] live;
		live = 19'b0111111_1001_11111001;
		for (int m = 0; m < 2; m++)
		begin
			host_u.wr(8'h23, m ? 8'h7F : 8'h00);
			host_u.wr(8'h24, m ? 8'h09 : 8'h00);
			host_u.wr(8'h25, m ? 8'hF9 : 8'h00);
			for (int k = 0; k < 19; k++)
				fire(k, live[k] && m == 0);
		end
	endtask
	task automatic tWatchdog();
		host_u.wr(8'h26, 8'h80);
		rdChk(8'h26, 8'h80);
		chk({15'h0000, convEnable}, 16'h0001);
		@(negedge sys_clk);
		watchdogExpired = 1'b1;
		@(negedge sys_clk);
		watchdogExpired = 1'b0;
		rdChk(8'h26, 8'h00);
		chk({15'h0000, convEnable}, 16'h0000);
	endtask
	task automatic tSamples();
		host_u.wr(8'h26, 8'h80);
		smp(16'h7FFE, 16'h7FFC, 16'h7FFC, 1'b0);
		resChk(8'h28, 16'h0FA0);
		resChk(8'h2A, 16'h0FA0);
		resChk(8'h2C, 16'h4E20);
		smp(16'h8000, 16'h0000, 16'h0000, 1'b1);
		resChk(8'h28, 16'hF060);
		resChk(8'h2A, 16'h8000);
		@(negedge sys_clk);
		chargeAllowWr = 1'b1;
		chargeAllow = 1'b0;
		fork
			begin
				@(negedge sys_clk);
				chargeAllowWr = 1'b0;
			end
			resChk(8'h2A, 16'h0000);
		join
		host_u.wr(8'h27, 8'h80);
		smp(16'h0100, 16'h0100, 16'h0100, 1'b0);
		resChk(8'h28, 16'hF060);
		resChk(8'h2C, 16'h0100);
		chk({8'h00, chanOff}, 16'h0080);
		host_u.wr(8'h26, 8'h88);
		smp(16'h0000, 16'h0100, 16'h0300, 1'b0);
		resChk(8'h2C, 16'h0200);
		host_u.wr(8'h26, 8'h80);
		host_u.wr(8'h26, 8'h8C);
		smp(16'h0000, 16'h0100, 16'h0800, 1'b0);
		resChk(8'h2C, 16'h0800);
		smp(16'h0000, 16'h0100, 16'h0400, 1'b0);
		resChk(8'h2C, 16'h0600);
		host_u.wr(8'h26, 8'h00);
		smp(16'h0200, 16'h0200, 16'h0200, 1'b0);
		resChk(8'h2A, 16'h0100);
	endtask
	task automatic tOneShot();
		int i;
		host_u.wr(8'h23, 8'h00);
		host_u.wr(8'h26, 8'hC0);
		@(negedge sys_clk);
		chk({15'h0000, convStart}, 16'h0001);
		for (i = 0; i < 40 && irq_n !== 1'b0; i++)
			@(negedge sys_clk);
		chk({15'h0000, irq_n}, 16'h0000);
		if (irq_n !== 1'b0)
			stop_test();
		@(negedge sys_clk);
		chk({15'h0000, convDoneFlag}, 16'h0001);
		host_u.wr(8'h23, 8'h40);
		repeat (8) @(negedge sys_clk);
		for (i = 0; i < 40 && irq_n !== 1'b0; i++)
			@(negedge sys_clk);
		chk({15'h0000, i == 40}, 16'h0001);
		host_u.wr(8'h26, 8'h00);
	endtask
	initial
	begin
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		tReset();
		tAccess();
		tEvents();
		tWatchdog();
		tSamples();
		tOneShot();
		stop_test();
	end
endmodule
`default_nettype wire
